// ---- fpd_cfg.svh ----
`ifndef FPD_CFG_SVH
`define FPD_CFG_SVH

// ----------------------------------------
// register indices, byte address is index * 4
// ----------------------------------------
`define FPD_IDX_ENH_CFG 8'h45
`define FPD_IDX_PWM_RPM_CFG 8'h4A
`define FPD_IDX_DUTY 8'h4C
`define FPD_IDX_FREQ 8'h4D
`define FPD_IDX_STATUS 8'h4E
`define FPD_ADDR_W 10

// ----------------------------------------
// field positions
// ----------------------------------------
`define FPD_BIT_HIGH_RES 4
`define FPD_BIT_BASE_CLK 3
`define FPD_FREQ_MSB 4
`define FPD_DUTY_LO_MSB 5
`define FPD_ST_HIRES 0
`define FPD_ST_SLOW 1
`define FPD_ST_ACTIVE 2
`define FPD_ST_PIN 3

// ----------------------------------------
// reset values and mode constants
// ----------------------------------------
`define FPD_RST_ENH_CFG 8'h00
`define FPD_RST_PWM_RPM_CFG 8'h00
`define FPD_RST_DUTY 8'h00
`define FPD_RST_FREQ 8'h08
`define FPD_HIRES_FREQ 5'h08
`define FPD_HIRES_FULL 8'hFF
`define FPD_FREQ_ZERO 5'h00
`define FPD_FREQ_ONE 5'h01

// ----------------------------------------
// timing: rates in Hz, cycle counts derived
// ----------------------------------------
`define FPD_CLK_HZ 250000000
`define FPD_FAST_BASE_HZ 360000
`define FPD_HIRES_OUT_HZ 22500
`define FPD_SLOW_PER_FAST 256
`define FPD_FAST_DIV (`FPD_CLK_HZ / `FPD_FAST_BASE_HZ)
`define FPD_HIRES_DIV (`FPD_CLK_HZ / (`FPD_HIRES_OUT_HZ * 255))

`endif

// ---- fpd_pkg.sv ----
package fpd_pkg;
  typedef enum logic [1:0] {
    FPD_BASE_FAST,
    FPD_BASE_SLOW,
    FPD_BASE_HIRES
  } fpd_base_t;
  typedef logic [7:0] fpd_byte_t;
endpackage

// ---- fpd_tick_div.sv ----
`timescale 1ns/10ps
// ----------------------------------------
// enable divider: one pulse every DIV enabled cycles
// ----------------------------------------
module fpd_tick_div #(
  parameter int DIV = 694
) (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // enable in, tick out
  input wire logic en,
  output logic tick
);
  localparam int W = (DIV > 1) ? $clog2(DIV) : 1;
  localparam logic [W-1:0] LAST = W'(DIV - 1);

  logic [W-1:0] cnt_reg;
  logic [W-1:0] cnt_next;
  logic tick_reg;
  logic tick_next;

  always_comb begin
    cnt_next = cnt_reg;
    tick_next = 1'b0;
    if (en) begin
      if (cnt_reg == LAST) begin
        cnt_next = '0;
        tick_next = 1'b1;
      end else begin
        cnt_next = cnt_reg + W'(1);
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_reg <= '0;
      tick_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      tick_reg <= tick_next;
    end
  end

  assign tick = tick_reg;
endmodule // fpd_tick_div

// ---- fpd_pwm_gen.sv ----
// The APB register port is this design's own decision.
`timescale 1ns/10ps
`include "fpd_cfg.svh"
module fpd_pwm_gen #(
  parameter int FAST_DIV = `FPD_FAST_DIV,
  parameter int HIRES_DIV = `FPD_HIRES_DIV,
  parameter int SLOW_PER_FAST = `FPD_SLOW_PER_FAST
) (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`FPD_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // open-drain fan pwm pin
  input wire logic fan_pwm_in,
  output logic fan_pwm_out,
  output logic fan_pwm_oe
);
  import fpd_pkg::*;

  // ----------------------------------------
  // registers
  // ----------------------------------------
  fpd_byte_t enh_cfg_reg, enh_cfg_next;
  fpd_byte_t rpm_cfg_reg, rpm_cfg_next;
  fpd_byte_t duty_reg, duty_next;
  fpd_byte_t freq_reg, freq_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [7:0] idx;
  logic addr_ok;
  logic wr_en;
  logic high_res_pwm_select;
  logic pwm_base_clock_select;
  fpd_byte_t status;

  assign idx = paddr[`FPD_ADDR_W-1:2];
  assign addr_ok = (paddr[1:0] == 2'h0) && (idx == `FPD_IDX_ENH_CFG || idx == `FPD_IDX_PWM_RPM_CFG
                   || idx == `FPD_IDX_DUTY || idx == `FPD_IDX_FREQ || idx == `FPD_IDX_STATUS);
  assign wr_en = psel && penable && pwrite && addr_ok;
  // zero wait states: every access completes in its first access cycle
  assign pready = 1'b1;
  assign pslverr = psel && penable && !addr_ok;
  assign high_res_pwm_select = enh_cfg_reg[`FPD_BIT_HIGH_RES];
  assign pwm_base_clock_select = rpm_cfg_reg[`FPD_BIT_BASE_CLK];

  always_comb begin
    enh_cfg_next = enh_cfg_reg;
    rpm_cfg_next = rpm_cfg_reg;
    duty_next = duty_reg;
    freq_next = freq_reg;
    rdata_next = rdata_reg;
    if (wr_en) begin
      case (idx)
        `FPD_IDX_ENH_CFG: begin
          enh_cfg_next = pwdata[7:0];
        end
        `FPD_IDX_PWM_RPM_CFG: begin
          rpm_cfg_next = pwdata[7:0];
        end
        `FPD_IDX_DUTY: begin
          duty_next = pwdata[7:0];
        end
        `FPD_IDX_FREQ: begin
          freq_next = pwdata[7:0];
        end
        default: begin
          freq_next = freq_reg;
        end
      endcase
    end
    // read data captured in the setup cycle so it leaves a flip-flop
    // a refused address reads zero even when its index would decode
    if (psel && !penable && !addr_ok) begin
      rdata_next = 32'h00000000;
    end else if (psel && !penable) begin
      case (idx)
        `FPD_IDX_ENH_CFG: rdata_next = {24'h000000, enh_cfg_reg};
        `FPD_IDX_PWM_RPM_CFG: rdata_next = {24'h000000, rpm_cfg_reg};
        `FPD_IDX_DUTY: rdata_next = {24'h000000, duty_reg};
        `FPD_IDX_FREQ: rdata_next = {24'h000000, freq_reg};
        `FPD_IDX_STATUS: rdata_next = {24'h000000, status};
        default: rdata_next = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      enh_cfg_reg <= `FPD_RST_ENH_CFG;
      rpm_cfg_reg <= `FPD_RST_PWM_RPM_CFG;
      duty_reg <= `FPD_RST_DUTY;
      freq_reg <= `FPD_RST_FREQ;
      rdata_reg <= 32'h00000000;
    end else begin
      enh_cfg_reg <= enh_cfg_next;
      rpm_cfg_reg <= rpm_cfg_next;
      duty_reg <= duty_next;
      freq_reg <= freq_next;
      rdata_reg <= rdata_next;
    end
  end

  assign prdata = rdata_reg;

  // ----------------------------------------
  // base clocks and mode select
  // ----------------------------------------
  logic fast_tick;
  logic slow_tick;
  logic hires_tick;
  logic hires;
  logic [4:0] freq_eff;
  fpd_base_t base_sel;
  logic base_tick;

  fpd_tick_div #(.DIV(FAST_DIV)) u_fast_div (
    .clk(clk),
    .arst_n(arst_n),
    .en(1'b1),
    .tick(fast_tick)
  );

  // the slow base is derived from the fast one so the two stay in ratio
  fpd_tick_div #(.DIV(SLOW_PER_FAST)) u_slow_div (
    .clk(clk),
    .arst_n(arst_n),
    .en(fast_tick),
    .tick(slow_tick)
  );

  fpd_tick_div #(.DIV(HIRES_DIV)) u_hires_div (
    .clk(clk),
    .arst_n(arst_n),
    .en(1'b1),
    .tick(hires_tick)
  );

  assign hires = high_res_pwm_select && !pwm_base_clock_select
                 && (freq_reg[`FPD_FREQ_MSB:0] == `FPD_HIRES_FREQ);
  // a frequency of zero behaves as one
  assign freq_eff = (freq_reg[`FPD_FREQ_MSB:0] == `FPD_FREQ_ZERO) ? `FPD_FREQ_ONE
                    : freq_reg[`FPD_FREQ_MSB:0];

  always_comb begin
    if (hires) begin
      base_sel = FPD_BASE_HIRES;
    end else if (pwm_base_clock_select) begin
      base_sel = FPD_BASE_SLOW;
    end else begin
      base_sel = FPD_BASE_FAST;
    end
    case (base_sel)
      FPD_BASE_HIRES: base_tick = hires_tick;
      FPD_BASE_SLOW: base_tick = slow_tick;
      FPD_BASE_FAST: base_tick = fast_tick;
      default: base_tick = fast_tick;
    endcase
  end

  // ----------------------------------------
  // period counter and compare
  // ----------------------------------------
  fpd_byte_t full_scale;
  fpd_byte_t duty_eff;
  fpd_byte_t cnt_reg, cnt_next;
  logic active_reg, active_next;
  logic [1:0] pin_sync_reg;

  assign full_scale = hires ? `FPD_HIRES_FULL : {2'h0, freq_eff, 1'b0};
  assign duty_eff = hires ? duty_reg : {2'h0, duty_reg[`FPD_DUTY_LO_MSB:0]};

  always_comb begin
    cnt_next = cnt_reg;
    // wrap also when a smaller period is written mid-cycle
    if (base_tick) begin
      if (cnt_reg >= full_scale - 8'h01) begin
        cnt_next = 8'h00;
      end else begin
        cnt_next = cnt_reg + 8'h01;
      end
    end
    active_next = (cnt_next < duty_eff);
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_reg <= 8'h00;
      active_reg <= 1'b0;
      pin_sync_reg <= 2'h0;
    end else begin
      cnt_reg <= cnt_next;
      active_reg <= active_next;
      pin_sync_reg <= {pin_sync_reg[0], fan_pwm_in};
    end
  end

  // active drive is released high by the fan pull-up, inactive pulls low
  assign fan_pwm_out = 1'b0;
  assign fan_pwm_oe = !active_reg;

  always_comb begin
    status = 8'h00;
    status[`FPD_ST_HIRES] = hires;
    status[`FPD_ST_SLOW] = (base_sel == FPD_BASE_SLOW);
    status[`FPD_ST_ACTIVE] = active_reg;
    status[`FPD_ST_PIN] = pin_sync_reg[1];
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  property p_hires_needs_all;
    @(posedge clk) disable iff (!arst_n)
    (wr_en && idx == `FPD_IDX_ENH_CFG && !pwdata[`FPD_BIT_HIGH_RES]) |=> !hires;
  endproperty
  a_hires_needs_all: assert property (p_hires_needs_all) else $error("hi-res kept without select bit");

  property p_slow_base;
    @(posedge clk) disable iff (!arst_n)
    pwm_base_clock_select |-> (!hires && base_tick == slow_tick);
  endproperty
  a_slow_base: assert property (p_slow_base) else $error("slow base clock not used");

  property p_hires_full_on;
    @(posedge clk) disable iff (!arst_n)
    (hires && duty_reg == `FPD_HIRES_FULL) [*2] |-> fan_pwm_oe == 1'b0;
  endproperty
  a_hires_full_on: assert property (p_hires_full_on) else $error("all ones not full duty");

  property p_freq_gate;
    @(posedge clk) disable iff (!arst_n)
    (wr_en && idx == `FPD_IDX_FREQ && pwdata[`FPD_FREQ_MSB:0] != `FPD_HIRES_FREQ) |=> !hires;
  endproperty
  a_freq_gate: assert property (p_freq_gate) else $error("hi-res with frequency not eight");

  property p_full_scale;
    @(posedge clk) disable iff (!arst_n)
    (!hires && freq_reg[`FPD_FREQ_MSB:0] == 5'h10) |-> full_scale == 8'h20;
  endproperty
  a_full_scale: assert property (p_full_scale) else $error("full scale not twice frequency");

  property p_zero_duty;
    @(posedge clk) disable iff (!arst_n)
    (duty_eff == 8'h00) [*2] |-> fan_pwm_oe;
  endproperty
  a_zero_duty: assert property (p_zero_duty) else $error("output active at zero duty");

  property p_low_six;
    @(posedge clk) disable iff (!arst_n)
    !hires |-> duty_eff[7:6] == 2'h0;
  endproperty
  a_low_six: assert property (p_low_six) else $error("upper duty bits used in normal mode");

  property p_period_wrap;
    @(posedge clk) disable iff (!arst_n)
    (base_tick && cnt_reg == full_scale - 8'h01 && $stable(full_scale)) |=> cnt_reg == 8'h00;
  endproperty
  a_period_wrap: assert property (p_period_wrap) else $error("period did not wrap at full scale");

  property p_count_holds;
    @(posedge clk) disable iff (!arst_n)
    !base_tick |=> $stable(cnt_reg);
  endproperty
  a_count_holds: assert property (p_count_holds) else $error("count moved without base tick");

  property p_hires_base;
    @(posedge clk) disable iff (!arst_n)
    hires |-> base_tick == hires_tick;
  endproperty
  a_hires_base: assert property (p_hires_base) else $error("hi-res mode not on its own base tick");

  property p_fast_base;
    @(posedge clk) disable iff (!arst_n)
    (!hires && !pwm_base_clock_select) |-> base_tick == fast_tick;
  endproperty
  a_fast_base: assert property (p_fast_base) else $error("fast base clock not used");

  property p_hires_byte;
    @(posedge clk) disable iff (!arst_n)
    hires |-> (full_scale == `FPD_HIRES_FULL && duty_eff == duty_reg);
  endproperty
  a_hires_byte: assert property (p_hires_byte) else $error("hi-res not using the full duty byte");

  property p_active_compare;
    @(posedge clk) disable iff (!arst_n)
    1'b1 |=> active_reg == (cnt_reg < $past(duty_eff));
  endproperty
  a_active_compare: assert property (p_active_compare) else $error("output level not count below duty");

  property p_count_range;
    @(posedge clk) disable iff (!arst_n)
    base_tick |=> (cnt_reg < full_scale) || $changed(full_scale);
  endproperty
  a_count_range: assert property (p_count_range) else $error("count left the period range");
endmodule // fpd_pwm_gen

// ---- fpd_fan_model.sv ----
`timescale 1ns/10ps
// ----------------------------------------
// fan pwm input behind a pull-up
// ----------------------------------------
module fpd_fan_model (
  // open-drain pin as driven by the block
  input wire logic pwm_out,
  input wire logic pwm_oe,
  // resolved wire level, fan running while high
  output logic pin,
  output logic running
);
  // a released line floats high through the pull-up, never holds the old level
  assign pin = pwm_oe ? pwm_out : 1'b1;
  assign running = pin;
endmodule // fpd_fan_model

// ---- fpd_pwm_gen_tb.sv ----
`timescale 1ns/10ps
module fpd_pwm_gen_tb;
  import fpd_pkg::*;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [9:0] paddr = 10'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, pwm_out, pwm_oe, pin, running;
  int mismatches = 0;
  int n_tests = 0;
  int cyc = 0;
  fpd_byte_t seed = 8'h4C;
  logic [32:0] expq[$];

  initial forever #2 clk = ~clk;

  // short dividers keep every period within a few hundred clocks
  fpd_pwm_gen #(.FAST_DIV(4), .HIRES_DIV(2), .SLOW_PER_FAST(4)) dut_u (.clk(clk), .arst_n(arst_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .fan_pwm_in(pin), .fan_pwm_out(pwm_out), .fan_pwm_oe(pwm_oe));
  fpd_fan_model fan_u (.pwm_out(pwm_out), .pwm_oe(pwm_oe), .pin(pin), .running(running));

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic check(input logic [32:0] seen, input logic [32:0] exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish;
    $display("mismatches %0d, checks %0d", mismatches, n_tests);
    if (mismatches == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  function automatic fpd_byte_t lfsr(input fpd_byte_t s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  // one transfer; a read notes {pslverr, prdata} for the monitor
  task automatic apb(input logic wr, input logic [9:0] a, input fpd_byte_t d, input logic [32:0] exp);
    @(posedge clk);
    if (!wr) expq.push_back(exp);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic cfg(input fpd_byte_t e, input fpd_byte_t r, input fpd_byte_t f, input fpd_byte_t d);
    apb(1'b1, 10'h114, e, 33'h0);
    apb(1'b1, 10'h128, r, 33'h0);
    apb(1'b1, 10'h134, f, 33'h0);
    apb(1'b1, 10'h130, d, 33'h0);
  endtask

  // settle past any old period, then count released cycles over two periods
  task automatic measure(input int per, input int act);
    int hi;
    hi = 0;
    repeat (1200) @(posedge clk);
    repeat (2 * per) begin
      @(posedge clk);
      if (pin === 1'b1) hi++;
    end
    check(33'(hi), 33'(2 * act));
  endtask

  // ----------------------------------------
  // read monitor and hang guard
  // ----------------------------------------
  always @(posedge clk) begin
    cyc++;
    if (psel && penable && pready && !pwrite && expq.size() > 0) check({pslverr, prdata}, expq.pop_front());
    // whole run needs about 16k cycles
    if (cyc == 40000) begin
      mismatches++;
      tally_and_finish();
    end
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    logic [9:0] ra [5];
    fpd_byte_t rv [5];
    fpd_byte_t fq [5];
    int full;
    ra = '{10'h114, 10'h128, 10'h130, 10'h134, 10'h138};
    rv = '{8'h00, 8'h00, 8'h00, 8'h08, 8'h00};
    fq = '{8'h00, 8'h01, 8'h02, 8'h10, 8'h1F};
    repeat (20) @(posedge clk);
    arst_n <= 1'b1;
    foreach (ra[i]) apb(1'b0, ra[i], 8'h00, {25'h0, rv[i]});
    apb(1'b1, 10'h3FC, 8'hAA, 33'h0);
    apb(1'b1, 10'h131, 8'hAA, 33'h0);
    apb(1'b0, 10'h3FC, 8'h00, 33'h100000000);
    apb(1'b0, 10'h130, 8'h00, 33'h0);
    // a nonzero duty makes the misaligned read able to show a leak
    apb(1'b1, 10'h130, 8'h5A, 33'h0);
    apb(1'b0, 10'h131, 8'h00, 33'h100000000);
    foreach (fq[i]) begin
      seed = lfsr(seed);
      cfg(8'h00, 8'h00, fq[i], seed);
      apb(1'b0, 10'h130, 8'h00, {25'h0, seed});
      full = (fq[i] == 8'h00) ? 2 : 2 * fq[i];
      measure(full * 4, ((seed[5:0] < full) ? seed[5:0] : full) * 4);
    end
    cfg(8'h00, 8'h08, 8'h02, 8'h03);
    measure(4 * 16, 3 * 16);
    cfg(8'h10, 8'h00, 8'h08, 8'hBF);
    measure(255 * 2, 191 * 2);
    cfg(8'h10, 8'h00, 8'h08, 8'hFF);
    measure(255 * 2, 255 * 2);
    apb(1'b0, 10'h138, 8'h00, 33'h00D);
    cfg(8'h10, 8'h08, 8'h08, 8'hBF);
    measure(16 * 16, 16 * 16);
    apb(1'b0, 10'h138, 8'h00, 33'h00E);
    cfg(8'h10, 8'h00, 8'h09, 8'h45);
    measure(18 * 4, 5 * 4);
    tally_and_finish();
  end
endmodule // fpd_pwm_gen_tb
